/* File: common/mbp_pkg.sv */
// shared types and constants for the multiplexed host bus port
package mbp_pkg;

	localparam int          DATA_W    = 8;
	localparam int          SYNC_DEPTH = 2;
	localparam int          MAX_SRC   = 8;
	localparam logic [7:0]  DOUT_RST  = 8'h00;
	localparam logic [7:0]  ADDR_RST  = 8'h00;

	// raw pin levels, sampled together through one synchroniser
	typedef struct packed {
		logic              addr_strobe_n;
		logic              data_strobe_n;
		logic              rd_wr_sel;
		logic              latched_select_n;
		logic              level_select;
		logic              irq_ack_n;
		logic              prio_chain_in;
		logic [DATA_W-1:0] muxed_addr_data;
	} mbp_pins_t;

	localparam mbp_pins_t PINS_RST = '{addr_strobe_n : 1'b1, data_strobe_n : 1'b1,
		rd_wr_sel : 1'b1, latched_select_n : 1'b1, level_select : 1'b0,
		irq_ack_n : 1'b1, prio_chain_in : 1'b0, muxed_addr_data : 8'h00};

	// what was caught on the rising address strobe
	typedef struct packed {
		logic [DATA_W-1:0] addr;
		logic              sel_n;
		logic              ack_n;
	} mbp_capt_t;

	localparam mbp_capt_t CAPT_RST = '{addr : 8'h00, sel_n : 1'b1, ack_n : 1'b1};

	typedef enum logic [2:0] {
		MBP_IDLE,
		MBP_ADDR,
		MBP_RD_FETCH,
		MBP_HOLD
	} mbp_state_t;

endpackage : mbp_pkg

/* File: hw/mbp_sync.sv */
// two-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ps
module mbp_sync #(
	parameter int           W       = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         core_clk_i,
	input  wire logic         arst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// meta_ff feeds sync_ff only; nothing else may look at it
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end
		else
		begin
			meta_ff <= d_i;
			sync_ff <= meta_ff;
		end
	end

	assign q_o = sync_ff;

endmodule : mbp_sync

/* File: hw/mbp_ius.sv */
// interrupt-under-service latches, one per source, lowest index wins
`timescale 1ns/1ps
module mbp_ius #(
	parameter int N_SRC = 6
) (
	input  wire logic             core_clk_i,
	input  wire logic             arst_n_i,
	input  wire logic [N_SRC-1:0] pend_i,
	input  wire logic             set_i,
	input  wire logic [N_SRC-1:0] clr_i,
	output logic      [N_SRC-1:0] ius_o
);

	logic [N_SRC-1:0] ius_ff;
	logic [N_SRC-1:0] nxt_ius;

	function automatic logic [N_SRC-1:0] first_one(input logic [N_SRC-1:0] v);
		logic [N_SRC-1:0] r;
		r = '0;
		for (int i = N_SRC - 1; i >= 0; i--)
			if (v[i])
				r = '0 | (N_SRC'(1) << i);
		return r;
	endfunction : first_one

	// a set arriving with a clear of the same bit wins
	always_comb
	begin
		nxt_ius = ius_ff & ~clr_i;
		if (set_i)
			nxt_ius = nxt_ius | first_one(pend_i);
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			ius_ff <= '0;
		else
			ius_ff <= nxt_ius;
	end

	assign ius_o = ius_ff;

	a_ius_set_one: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(set_i && (pend_i != '0)) |=> ((ius_ff & $past(first_one(pend_i))) != '0))
		else $error("acknowledged source did not enter service");

	a_ius_no_spurious: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(!set_i) |=> ((ius_ff & ~$past(ius_ff)) == '0))
		else $error("service latch set without an acknowledge");

endmodule : mbp_ius

/* File: hw/mbp_port.sv */
// multiplexed address/data host bus port with interrupt acknowledge
// Behaviour
// - address, latched select and acknowledge level are caught on address strobe rising.
// - reads happen only with level select high; otherwise bus stays undriven.
// - read data drives the bus only while data strobe is low.
// - writes need level select high; host supplies write data on the bus.
// - write data is taken into the addressed register while data strobe is low.
// - acknowledge cycles ignore address, both selects and read/write select.
// - priority chains settle between address strobe rise and data strobe fall.
// - acknowledge is ours only with an interrupt pending and chain input high.
// - an owned acknowledge drives the vector while data strobe is low, if enabled.
// - an owned acknowledge sets the service latch of the acknowledged source.
`timescale 1ns/1ps
module mbp_port #(
	parameter int N_SRC = 6
) (
	input  wire logic                       core_clk_i,
	input  wire logic                       arst_n_i,
	input  wire logic                       addr_strobe_n_i,
	input  wire logic                       data_strobe_n_i,
	input  wire logic                       rd_wr_sel_i,
	input  wire logic                       latched_select_n_i,
	input  wire logic                       level_select_i,
	input  wire logic                       irq_ack_n_i,
	input  wire logic                       prio_chain_in_i,
	input  wire logic [mbp_pkg::DATA_W-1:0] muxed_addr_data_i,
	output logic      [mbp_pkg::DATA_W-1:0] muxed_addr_data_o,
	output logic                            muxed_addr_data_oe_o,
	output logic                            prio_chain_out_o,
	output logic      [mbp_pkg::DATA_W-1:0] reg_addr_o,
	output logic      [mbp_pkg::DATA_W-1:0] reg_wdata_o,
	output logic                            reg_wr_o,
	output logic                            reg_rd_o,
	input  wire logic [mbp_pkg::DATA_W-1:0] reg_rdata_i,
	input  wire logic [N_SRC-1:0]           irq_pend_i,
	input  wire logic                       vec_resp_en_i,
	input  wire logic [mbp_pkg::DATA_W-1:0] vector_i,
	input  wire logic [N_SRC-1:0]           ius_clr_i,
	output logic      [N_SRC-1:0]           ius_o
);

	if (N_SRC < 1 || N_SRC > mbp_pkg::MAX_SRC)
	begin : g_bad_src
		$error("N_SRC out of range");
	end

	mbp_pkg::mbp_pins_t  pins_raw;
	mbp_pkg::mbp_pins_t  pin_s;
	mbp_pkg::mbp_pins_t  pin_q_ff;
	mbp_pkg::mbp_capt_t  capt_ff;
	mbp_pkg::mbp_capt_t  nxt_capt;
	mbp_pkg::mbp_state_t state_ff;
	mbp_pkg::mbp_state_t nxt_state;
	logic [mbp_pkg::DATA_W-1:0] dout_ff;
	logic [mbp_pkg::DATA_W-1:0] nxt_dout;
	logic [mbp_pkg::DATA_W-1:0] wdata_ff;
	logic [mbp_pkg::DATA_W-1:0] nxt_wdata;
	logic                       oe_ff;
	logic                       nxt_oe;
	logic                       rd_cyc_ff;
	logic                       nxt_rd_cyc;
	logic                       wr_ff;
	logic                       nxt_wr;
	logic                       rd_ff;
	logic                       nxt_rd;
	logic                       ieo_ff;
	logic                       nxt_ieo;
	logic                       ius_set;
	logic                       as_rise;
	logic                       ds_fall;
	logic                       ds_rise;
	logic                       acc_ok;
	logic                       ack_own;
	logic                       rd_go;
	logic                       wr_go;
	logic                       ack_phase;

	assign pins_raw = '{addr_strobe_n : addr_strobe_n_i, data_strobe_n : data_strobe_n_i,
		rd_wr_sel : rd_wr_sel_i, latched_select_n : latched_select_n_i,
		level_select : level_select_i, irq_ack_n : irq_ack_n_i,
		prio_chain_in : prio_chain_in_i, muxed_addr_data : muxed_addr_data_i};

	// strobes have no phase relation to core_clk_i, so every pin is synchronised;
	// the two-cycle latency is why the host must leave a recovery gap
	mbp_sync #(
		.W       ($bits(mbp_pkg::mbp_pins_t)),
		.RST_VAL (mbp_pkg::PINS_RST)
	) u_sync (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.d_i        (pins_raw),
		.q_o        (pin_s)
	);

	mbp_ius #(
		.N_SRC (N_SRC)
	) u_ius (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.pend_i     (irq_pend_i),
		.set_i      (ius_set),
		.clr_i      (ius_clr_i),
		.ius_o      (ius_o)
	);

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			pin_q_ff <= mbp_pkg::PINS_RST;
		else
			pin_q_ff <= pin_s;
	end

	assign as_rise   = !pin_q_ff.addr_strobe_n && pin_s.addr_strobe_n;
	assign ds_fall   = pin_q_ff.data_strobe_n && !pin_s.data_strobe_n;
	assign ds_rise   = !pin_q_ff.data_strobe_n && pin_s.data_strobe_n;
	assign acc_ok    = !capt_ff.sel_n && capt_ff.ack_n;
	assign ack_own   = (irq_pend_i != '0) && pin_s.prio_chain_in;
	assign rd_go     = state_ff == mbp_pkg::MBP_ADDR && ds_fall && acc_ok
		&& pin_s.level_select && pin_s.rd_wr_sel;
	assign wr_go     = state_ff == mbp_pkg::MBP_ADDR && ds_fall && acc_ok
		&& pin_s.level_select && !pin_s.rd_wr_sel;
	assign ack_phase = state_ff != mbp_pkg::MBP_IDLE && !capt_ff.ack_n;

	always_comb
	begin
		nxt_state  = state_ff;
		nxt_capt   = capt_ff;
		nxt_dout   = dout_ff;
		nxt_wdata  = wdata_ff;
		nxt_oe     = oe_ff;
		nxt_rd_cyc = rd_cyc_ff;
		nxt_wr     = 1'b0;
		nxt_rd     = 1'b0;
		ius_set    = 1'b0;
		if (as_rise)
		begin
			nxt_capt  = '{addr : pin_s.muxed_addr_data, sel_n : pin_s.latched_select_n,
				ack_n : pin_s.irq_ack_n};
			nxt_state = mbp_pkg::MBP_ADDR;
			nxt_oe    = 1'b0;
		end
		else
		begin
			unique case (state_ff)
				mbp_pkg::MBP_IDLE:
				begin
					nxt_oe = 1'b0;
				end
				mbp_pkg::MBP_ADDR:
				begin
					nxt_rd_cyc = 1'b0;
					if (ds_fall)
					begin
						nxt_state = mbp_pkg::MBP_HOLD;
						if (!capt_ff.ack_n)
						begin
							// selects and direction play no part here
							if (ack_own)
							begin
								ius_set = 1'b1;
								if (vec_resp_en_i)
								begin
									nxt_dout = vector_i;
									nxt_oe   = 1'b1;
								end
							end
						end
						else if (rd_go)
						begin
							nxt_rd     = 1'b1;
							nxt_rd_cyc = 1'b1;
							nxt_state  = mbp_pkg::MBP_RD_FETCH;
						end
						else if (wr_go)
						begin
							nxt_wr    = 1'b1;
							nxt_wdata = pin_s.muxed_addr_data;
						end
					end
				end
				mbp_pkg::MBP_RD_FETCH:
				begin
					// register file answers in the cycle reg_rd_o is high
					nxt_dout  = reg_rdata_i;
					nxt_oe    = !pin_s.data_strobe_n && pin_s.level_select;
					nxt_state = pin_s.data_strobe_n ? mbp_pkg::MBP_IDLE : mbp_pkg::MBP_HOLD;
				end
				mbp_pkg::MBP_HOLD:
				begin
					if (pin_s.data_strobe_n)
					begin
						nxt_oe    = 1'b0;
						nxt_state = mbp_pkg::MBP_IDLE;
					end
					else if (rd_cyc_ff && !pin_s.level_select)
						nxt_oe = 1'b0;
				end
			endcase
		end
	end

	// chain passes on only when nothing here is in service or being acknowledged
	always_comb
	begin
		nxt_ieo = pin_s.prio_chain_in && (ius_o == '0) && !(ack_phase && irq_pend_i != '0);
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_ff  <= mbp_pkg::MBP_IDLE;
			capt_ff   <= mbp_pkg::CAPT_RST;
			dout_ff   <= mbp_pkg::DOUT_RST;
			wdata_ff  <= mbp_pkg::DOUT_RST;
			oe_ff     <= 1'b0;
			rd_cyc_ff <= 1'b0;
			wr_ff     <= 1'b0;
			rd_ff     <= 1'b0;
			ieo_ff    <= 1'b0;
		end
		else
		begin
			state_ff  <= nxt_state;
			capt_ff   <= nxt_capt;
			dout_ff   <= nxt_dout;
			wdata_ff  <= nxt_wdata;
			oe_ff     <= nxt_oe;
			rd_cyc_ff <= nxt_rd_cyc;
			wr_ff     <= nxt_wr;
			rd_ff     <= nxt_rd;
			ieo_ff    <= nxt_ieo;
		end
	end

	assign muxed_addr_data_o    = dout_ff;
	assign muxed_addr_data_oe_o = oe_ff;
	assign prio_chain_out_o     = ieo_ff;
	assign reg_addr_o           = capt_ff.addr;
	assign reg_wdata_o          = wdata_ff;
	assign reg_wr_o             = wr_ff;
	assign reg_rd_o             = rd_ff;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	sequence s_rd_req;
		rd_go;
	endsequence

	sequence s_wr_req;
		wr_go;
	endsequence

	sequence s_ack_vec;
		state_ff == mbp_pkg::MBP_ADDR && ds_fall && !capt_ff.ack_n && ack_own && vec_resp_en_i;
	endsequence

	a_capture_addr: assert property (
		as_rise |=> (reg_addr_o == $past(pin_s.muxed_addr_data))
			&& (capt_ff.ack_n == $past(pin_s.irq_ack_n)))
		else $error("address strobe capture wrong");

	a_oe_needs_ds: assert property (
		$rose(muxed_addr_data_oe_o) |-> $past(!pin_s.data_strobe_n))
		else $error("bus driven without data strobe low");

	a_ds_rise_release: assert property (
		(ds_rise && !as_rise) |=> !muxed_addr_data_oe_o)
		else $error("bus not released after data strobe rise");

	a_read_level: assert property (
		(muxed_addr_data_oe_o && capt_ff.ack_n) |-> $past(pin_s.level_select))
		else $error("read driven without level select");

	a_read_walk: assert property (
		s_rd_req |=> reg_rd_o ##1 (muxed_addr_data_o == $past(reg_rdata_i)) ##1 !reg_rd_o)
		else $error("read sequence wrong");

	a_write_walk: assert property (
		s_wr_req |=> reg_wr_o && (reg_wdata_o == $past(pin_s.muxed_addr_data)) ##1 !reg_wr_o)
		else $error("write sequence wrong");

	a_ack_ignore: assert property (
		(ds_fall && !capt_ff.ack_n) |=> !reg_wr_o && !reg_rd_o)
		else $error("register access during acknowledge");

	a_ack_vector: assert property (
		s_ack_vec |=> muxed_addr_data_oe_o && (muxed_addr_data_o == $past(vector_i)))
		else $error("vector not driven on owned acknowledge");

	a_ack_not_own: assert property (
		(state_ff == mbp_pkg::MBP_ADDR && ds_fall && !capt_ff.ack_n && !ack_own)
			|=> !muxed_addr_data_oe_o)
		else $error("vector driven on foreign acknowledge");

	a_no_sel_access: assert property (
		(state_ff == mbp_pkg::MBP_ADDR && ds_fall && !acc_ok) |=> !reg_wr_o && !reg_rd_o)
		else $error("access taken while not selected");

	// a source in service must block the chain, or two devices answer one acknowledge
	a_chain_block: assert property (
		(ius_o != '0) |=> !prio_chain_out_o)
		else $error("chain passed on while a source is in service");

endmodule : mbp_port

/* File: sim/mbp_host_model.sv */
// host processor model driving the multiplexed bus pins
`timescale 1ns/1ps
module mbp_host_model (
	input  wire logic       core_clk_i,
	output logic            addr_strobe_n_o,
	output logic            data_strobe_n_o,
	output logic            rd_wr_sel_o,
	output logic            latched_select_n_o,
	output logic            level_select_o,
	output logic            irq_ack_n_o,
	output logic            bus_oe_o,
	output logic [7:0]      bus_o
);
	initial
	begin
		addr_strobe_n_o    = 1'b1;
		data_strobe_n_o    = 1'b1;
		rd_wr_sel_o        = 1'b1;
		latched_select_n_o = 1'b1;
		level_select_o     = 1'b0;
		irq_ack_n_o        = 1'b1;
		bus_oe_o           = 1'b0;
		bus_o              = 8'h00;
	end

	// pins change only at edges and stand several clocks, since the port synchronises them
	task automatic hold(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : hold

	task automatic run(input logic [7:0] a, input logic [7:0] d, input logic rd,
		input logic s_n, input logic lv, input logic ak_n, input logic cut);
		@(posedge core_clk_i);
		addr_strobe_n_o    <= 1'b0;
		bus_o              <= a;
		bus_oe_o           <= 1'b1;
		rd_wr_sel_o        <= rd;
		latched_select_n_o <= s_n;
		level_select_o     <= lv;
		irq_ack_n_o        <= ak_n;
		hold(4);
		addr_strobe_n_o    <= 1'b1;
		hold(6);
		bus_o              <= d;
		bus_oe_o           <= !rd && ak_n;
		hold(2);
		data_strobe_n_o    <= 1'b0;
		hold(3);
		// a read may lose level select while data strobe is still low
		if (cut)
			level_select_o <= 1'b0;
		hold(3);
		data_strobe_n_o    <= 1'b1;
		hold(4);
		bus_oe_o           <= 1'b0;
		hold(4);
	endtask : run
endmodule : mbp_host_model

/* File: sim/tb_muxed_bus_host_port.sv */
// self-checking bench for the multiplexed host bus port
`timescale 1ns/1ps
module tb_muxed_bus_host_port;
	localparam int NS = 6;
	typedef struct packed {logic [1:0] kind; logic [15:0] val;} mbp_note_t;

	logic          core_clk, arst_n, as_n, ds_n, rw, sel_n, lvl, ack_n;
	logic          host_oe, dev_oe, chain_in, chain_out, reg_wr, reg_rd, vec_en, oe_seen;
	logic [7:0]    host_bus, dev_bus, bus_wire, reg_addr, reg_wdata, rdata, vector, a_r, d_r;
	logic [NS-1:0] pend, ius_clr, ius, exp_ius;
	mbp_note_t     notes[$];
	int            mismatches, check_count, i, k, seed;

	// a released bus shows the inverse of host_bus, never a stale match
	assign bus_wire = dev_oe ? dev_bus : (host_oe ? host_bus : ~host_bus);
	assign rdata    = ~reg_addr;

	mbp_port #(.N_SRC(NS)) i_mbp_port (
		.core_clk_i(core_clk), .arst_n_i(arst_n), .addr_strobe_n_i(as_n),
		.data_strobe_n_i(ds_n), .rd_wr_sel_i(rw), .latched_select_n_i(sel_n),
		.level_select_i(lvl), .irq_ack_n_i(ack_n), .prio_chain_in_i(chain_in),
		.muxed_addr_data_i(bus_wire), .muxed_addr_data_o(dev_bus),
		.muxed_addr_data_oe_o(dev_oe), .prio_chain_out_o(chain_out),
		.reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr),
		.reg_rd_o(reg_rd), .reg_rdata_i(rdata), .irq_pend_i(pend),
		.vec_resp_en_i(vec_en), .vector_i(vector), .ius_clr_i(ius_clr), .ius_o(ius));

	mbp_host_model i_mbp_host_model (
		.core_clk_i(core_clk), .addr_strobe_n_o(as_n), .data_strobe_n_o(ds_n),
		.rd_wr_sel_o(rw), .latched_select_n_o(sel_n), .level_select_o(lvl),
		.irq_ack_n_o(ack_n), .bus_oe_o(host_oe), .bus_o(host_bus));

	initial core_clk = 1'b0;
	always #50 core_clk = ~core_clk;

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	task automatic check(input string nm, input logic [17:0] exp, input logic [17:0] got);
		check_count++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", nm, exp, got);
			mismatches++;
		end
	endtask : check

	task automatic take(input string nm, input mbp_note_t got);
		if (notes.size() == 0)
		begin
			$display("unexpected %s expected none seen %h", nm, got);
			mismatches++;
		end
		else
			check(nm, notes.pop_front(), got);
	endtask : take

	// one bus cycle; expectations come from the selects and levels handed in
	task automatic access(input logic [7:0] a, input logic [7:0] d, input logic rd,
		input logic s_n, input logic lv, input logic ak_n);
		logic [NS-1:0] low;
		low = pend & (~pend + NS'(1));
		if (ak_n && !s_n && lv)
			notes.push_back({rd ? 2'd1 : 2'd0, a, rd ? 8'h00 : d});
		if (ak_n && !s_n && lv && rd)
			notes.push_back({2'd2, 8'h00, ~a});
		if (!ak_n && pend != '0 && chain_in)
		begin
			exp_ius = exp_ius | low;
			if (vec_en)
				notes.push_back({2'd2, 8'h00, vector});
		end
		i_mbp_host_model.run(a, d, rd, s_n, lv, ak_n, rd && i[0]);
		check("oe released", 18'h0, 18'(dev_oe));
		check("service latch", 18'(exp_ius), 18'(ius));
		check("chain out", 18'(chain_in && exp_ius == '0), 18'(chain_out));
	endtask : access

	always @(negedge core_clk)
	begin
		if (reg_wr === 1'b1)
			take("write", {2'd0, reg_addr, reg_wdata});
		if (reg_rd === 1'b1)
			take("read", {2'd1, reg_addr, 8'h00});
		if (dev_oe === 1'b1 && oe_seen !== 1'b1)
		begin
			take("bus drive", {2'd2, 8'h00, bus_wire});
			check("strobe at drive", 18'h0, 18'(ds_n));
		end
		oe_seen = dev_oe;
	end

	initial
	begin
		repeat (60000) @(posedge core_clk);
		mismatches++;
		summarize();
	end

	initial
	begin
		seed = 9146;
		arst_n = 1'b0;
		chain_in = 1'b1;
		pend = '0;
		vec_en = 1'b1;
		vector = 8'h00;
		ius_clr = '0;
		exp_ius = '0;
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		@(negedge core_clk);
		check("reset oe", 18'h0, 18'(dev_oe));
		check("reset chain", 18'h0, 18'(chain_out));
		check("reset service", 18'h0, 18'(ius));
		check("reset address", 18'h0, 18'(reg_addr));
		for (i = 0; i < 6; i++)
		begin
			a_r = 8'($random(seed));
			d_r = 8'($random(seed));
			access(a_r, d_r, 1'b0, 1'b0, 1'b1, 1'b1);
			access(a_r, d_r, 1'b1, 1'b0, 1'b1, 1'b1);
		end
		access(a_r, d_r, 1'b1, 1'b0, 1'b0, 1'b1);
		access(a_r, d_r, 1'b0, 1'b0, 1'b0, 1'b1);
		access(a_r, d_r, 1'b0, 1'b1, 1'b1, 1'b1);
		access(a_r, d_r, 1'b1, 1'b1, 1'b1, 1'b1);
		for (i = 0; i < 4; i++)
		begin
			@(posedge core_clk);
			vector   <= 8'($random(seed));
			pend     <= (i == 3) ? NS'(0) : (NS'($random(seed)) | NS'(8'h20));
			chain_in <= (i != 1);
			vec_en   <= (i != 2);
			@(posedge core_clk);
			access(8'($random(seed)), 8'h3C, 1'b0, 1'b1, 1'b0, 1'b0);
			ius_clr  <= '1;
			@(posedge core_clk);
			ius_clr  <= '0;
			exp_ius  = '0;
		end
		for (k = 0; k < 20 && notes.size() > 0; k++)
			@(posedge core_clk);
		if (notes.size() != 0)
		begin
			$display("unexpected pending notes expected 0 seen %0d", notes.size());
			mismatches++;
		end
		summarize();
	end
endmodule : tb_muxed_bus_host_port
